// *** include/vsc_pkg.sv ***
// Package for the vertical sequence mode control register block.
// Assumes a single 250 MHz clock and an APB register bus of 32-bit data.
package vsc_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [11:0] VSC_MODE_CTRL_OFS = 12'h000;
    localparam logic [11:0] VSC_STATUS_OFS = 12'h004;
    localparam int VSC_REG_W = 22;
    localparam logic [21:0] VSC_MODE_CTRL_RST = 22'h000000;
    localparam logic [1:0] VSC_BLANK_RESERVED = 2'h2;
    localparam logic [3:0] VSC_COMBINE_ON = 4'h1;
    localparam int VSC_CLK_MHZ = 250;

    // ----------------------------------------
    // Field layout
    // ----------------------------------------
    typedef struct packed {
        logic [1:0] horizontal_blanking_mode;
        logic [3:0] final_repeat_length_enable;
        logic [1:0] alternation_repeat_mode;
        logic [3:0] group_combine;
        logic [2:0] special_pattern_insert_enable;
        logic special_alternation_enable;
        logic [3:0] hold_enable;
        logic preblank_start_polarity;
        logic clamp_start_polarity;
    } vsc_ctrl_s;

    typedef enum logic [1:0] {
        VSC_ALT_SINGLE = 2'h0,
        VSC_ALT_TWO = 2'h1,
        VSC_ALT_A3_BCD011 = 2'h2,
        VSC_ALT_A4_BCD2 = 2'h3
    } vsc_alt_e;

    // Per-group alternation scheme: pattern count and irregular 0,1,1 flag
    typedef struct packed {
        logic [2:0] pattern_count;
        logic skip_first;
    } vsc_alt_s;
endpackage

// *** hw/vsc_mode_ctrl.sv ***
// Vertical sequence mode control register with APB access and decoded controls.
// Assumes APB master on clk_in; sequencer pulses update point to apply settings.
//
// Contract
// - Bits 5:2 enable the hold function of pattern groups A to D.
// - Bit 6 enables special alternation of the vertical sequence.
// - Bits 9:7 insert pattern B, C or D into the group A sequence.
// - Bits 13:10 combine groups into one sequence when equal to 0x01.
// - Mode code 00 gives single and 01 gives two-pattern alternation for all groups.
// - Mode code 10 gives group A three-pattern, groups B to D the 0,1,1 sequence.
// - Mode code 11 gives group A four-pattern and groups B to D two-pattern.
// - Bits 19:16 enable a separate final repetition length per group, A in bit 16.
// - Blanking mode code 00 is normal six-toggle mode 0, code 01 is mode 1.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
module vsc_mode_ctrl (
    // Clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Sequencer side
    input wire logic sequence_change_update_point_in,
    output logic clamp_start_polarity_out,
    output logic preblank_start_polarity_out,
    output logic [3:0] hold_enable_out,
    output logic special_alternation_enable_out,
    output logic [2:0] special_pattern_insert_enable_out,
    output logic group_combine_active_out,
    output vsc_pkg::vsc_alt_s [3:0] group_alternation_out,
    output logic [3:0] final_repeat_length_enable_out,
    output logic horizontal_blanking_mode1_out,
    output logic horizontal_blanking_test_out
);
    // ----------------------------------------
    // Constants and bus decode
    // ----------------------------------------
    // Decoded value of one group for mode code 00, also its reset value
    localparam vsc_pkg::vsc_alt_s ALT_IDLE = '{pattern_count: 3'h1, skip_first: 1'b0};

    logic hit_ctrl;
    logic hit_stat;
    logic access_ph;
    logic setup_rd;
    logic wr_ctrl;

    assign hit_ctrl = (paddr == vsc_pkg::VSC_MODE_CTRL_OFS);
    assign hit_stat = (paddr == vsc_pkg::VSC_STATUS_OFS);
    assign access_ph = psel && penable;
    assign setup_rd = psel && !penable && !pwrite;
    // Writes land only at the access edge, never in setup
    assign wr_ctrl = access_ph && pwrite && hit_ctrl;
    // Zero wait states; unmapped addresses and status writes error
    assign pready = 1'b1;
    assign pslverr = access_ph && !hit_ctrl && !(hit_stat && !pwrite);

    // ----------------------------------------
    // Shadow word, as last written
    // ----------------------------------------
    vsc_pkg::vsc_ctrl_s shadow_r;
    vsc_pkg::vsc_ctrl_s shadow_nxt;
    logic written_r;
    logic written_nxt;

    always_comb begin
        shadow_nxt = shadow_r;
        written_nxt = written_r;
        if (wr_ctrl) begin
            // Bits above the register width are dropped on purpose
            shadow_nxt = vsc_pkg::vsc_ctrl_s'(pwdata[vsc_pkg::VSC_REG_W-1:0]);
            written_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            shadow_r <= vsc_pkg::vsc_ctrl_s'(vsc_pkg::VSC_MODE_CTRL_RST);
            written_r <= 1'b0;
        end else begin
            shadow_r <= shadow_nxt;
            written_r <= written_nxt;
        end
    end

    // ----------------------------------------
    // Active word, loaded at the update point
    // ----------------------------------------
    vsc_pkg::vsc_ctrl_s active_r;
    vsc_pkg::vsc_ctrl_s active_nxt;
    logic pending_r;
    logic pending_nxt;

    // Settings apply only at the update point so lines never see a half change;
    // a write in the same cycle as the pulse goes straight through
    always_comb begin
        active_nxt = active_r;
        pending_nxt = pending_r;
        if (sequence_change_update_point_in && (pending_r || wr_ctrl)) begin
            active_nxt = shadow_nxt;
            pending_nxt = 1'b0;
        end else if (wr_ctrl) begin
            pending_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            active_r <= vsc_pkg::vsc_ctrl_s'(vsc_pkg::VSC_MODE_CTRL_RST);
            pending_r <= 1'b0;
        end else begin
            active_r <= active_nxt;
            pending_r <= pending_nxt;
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic blank_reserved;

    assign blank_reserved =
        (shadow_r.horizontal_blanking_mode == vsc_pkg::VSC_BLANK_RESERVED);

    always_comb begin
        prdata_nxt = prdata_r;
        // Loaded in the setup cycle so it stands through the whole access phase
        if (setup_rd) begin
            if (hit_ctrl) begin
                prdata_nxt = {10'h000, shadow_r};
            end else if (hit_stat) begin
                prdata_nxt = {29'h0000000, blank_reserved, written_r, pending_r};
            end else begin
                prdata_nxt = 32'h00000000;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            prdata_r <= 32'h00000000;
        end else begin
            prdata_r <= prdata_nxt;
        end
    end

    assign prdata = prdata_r;

    // ----------------------------------------
    // Decoded word-wide controls
    // ----------------------------------------
    logic combine_r;
    logic combine_nxt;
    logic blank_mode1_r;
    logic blank_mode1_nxt;
    logic blank_test_r;
    logic blank_test_nxt;

    // Decoded from the next active word so the flags move with active_r
    always_comb begin
        combine_nxt = (active_nxt.group_combine == vsc_pkg::VSC_COMBINE_ON);
        blank_mode1_nxt = (active_nxt.horizontal_blanking_mode == 2'h1);
        // Reserved test code is only flagged; nothing else reacts to it
        blank_test_nxt =
            (active_nxt.horizontal_blanking_mode == vsc_pkg::VSC_BLANK_RESERVED);
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            combine_r <= 1'b0;
            blank_mode1_r <= 1'b0;
            blank_test_r <= 1'b0;
        end else begin
            combine_r <= combine_nxt;
            blank_mode1_r <= blank_mode1_nxt;
            blank_test_r <= blank_test_nxt;
        end
    end

    // ----------------------------------------
    // Per-group alternation scheme
    // ----------------------------------------
    vsc_pkg::vsc_alt_s alt_r [4];
    vsc_pkg::vsc_alt_s alt_nxt [4];
    genvar g;

    generate
        for (g = 0; g < 4; g++) begin : g_grp
            always_comb begin
                alt_nxt[g] = ALT_IDLE;
                case (vsc_pkg::vsc_alt_e'(active_nxt.alternation_repeat_mode))
                    vsc_pkg::VSC_ALT_SINGLE: alt_nxt[g].pattern_count = 3'h1;
                    vsc_pkg::VSC_ALT_TWO: alt_nxt[g].pattern_count = 3'h2;
                    vsc_pkg::VSC_ALT_A3_BCD011: begin
                        // Groups B to D run a three-step 0,1,1 cycle
                        alt_nxt[g].pattern_count = 3'h3;
                        alt_nxt[g].skip_first = (g != 0) ? 1'b1 : 1'b0;
                    end
                    vsc_pkg::VSC_ALT_A4_BCD2:
                        alt_nxt[g].pattern_count = (g == 0) ? 3'h4 : 3'h2;
                    default: alt_nxt[g].pattern_count = 3'h1;
                endcase
            end

            always_ff @(posedge clk_in) begin
                if (srst_in) begin
                    alt_r[g] <= ALT_IDLE;
                end else begin
                    alt_r[g] <= alt_nxt[g];
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Polarity bits pass straight from the active word
    assign clamp_start_polarity_out = active_r.clamp_start_polarity;
    assign preblank_start_polarity_out = active_r.preblank_start_polarity;
    assign hold_enable_out = active_r.hold_enable;
    assign special_alternation_enable_out = active_r.special_alternation_enable;
    assign special_pattern_insert_enable_out = active_r.special_pattern_insert_enable;
    assign final_repeat_length_enable_out = active_r.final_repeat_length_enable;
    assign group_combine_active_out = combine_r;
    assign horizontal_blanking_mode1_out = blank_mode1_r;
    assign horizontal_blanking_test_out = blank_test_r;
    assign group_alternation_out = {alt_r[3], alt_r[2], alt_r[1], alt_r[0]};
endmodule

// *** sim/vsc_mode_ctrl_checker.sv ***
// Checker for the mode control register.
// Assumes writes to offset 0 and a one-cycle update pulse.
`timescale 1ns/1ps
module vsc_mode_ctrl_checker (
    input wire logic clk_in, srst_in, psel, penable, pwrite, pslverr,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic sequence_change_update_point_in, special_alternation_enable_out,
    input wire logic group_combine_active_out, horizontal_blanking_mode1_out,
    input wire logic horizontal_blanking_test_out,
    input wire logic [3:0] hold_enable_out, final_repeat_length_enable_out,
    input wire logic [2:0] special_pattern_insert_enable_out,
    input wire vsc_pkg::vsc_alt_s [3:0] group_alternation_out
);
    // ----
    // Pending value model
    // ----
    localparam logic [15:0] ALT [4] = '{16'h2222, 16'h4444, 16'h7776, 16'h4448};
    logic [21:0] sh_r, sh_nxt, sel, prv_r;
    logic wr, upd;
    assign wr = psel && penable && pwrite && paddr == 12'h000;
    assign upd = sequence_change_update_point_in;
    // Same-cycle write and pulse applies the new word
    assign sel = wr ? pwdata[21:0] : sh_r;
    always_comb sh_nxt = srst_in ? 22'h000000 : sel;
    always_ff @(posedge clk_in) begin
        sh_r <= sh_nxt;
        prv_r <= sel;
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (srst_in);
    sequence upd_s;
        upd ##1 1'b1;
    endsequence
    hold_map_a: assert property (upd_s |-> hold_enable_out == prv_r[5:2]) else $error("hold");
    alt_en_a: assert property (upd |=> special_alternation_enable_out == prv_r[6]) else $error("alt");
    ins_map_a: assert property (upd |=> special_pattern_insert_enable_out == prv_r[9:7]) else $error("ins");
    combine_a: assert property (upd |=> group_combine_active_out == (prv_r[13:10] == 4'h1)) else $error("comb");
    rep_mode_a: assert property (upd_s |-> group_alternation_out == ALT[prv_r[15:14]]) else $error("mode");
    fin_len_a: assert property (upd |=> final_repeat_length_enable_out == prv_r[19:16]) else $error("fin");
    blank_mode_a: assert property (upd |=> horizontal_blanking_mode1_out == (prv_r[21:20] == 2'h1)
        && horizontal_blanking_test_out == (prv_r[21:20] == 2'h2)) else $error("blank");
    // Reset edges are left out: outputs may legally change after them
    hold_keep_a: assert property (!upd && !srst_in |=> $stable(hold_enable_out)
        && $stable(group_alternation_out)) else $error("change without update");
    slv_err_a: assert property (psel && penable |-> pslverr == (paddr != 12'h000
        && !(paddr == 12'h004 && !pwrite))) else $error("slave error");
    cover property (wr ##[1:8] upd);
endmodule
bind vsc_mode_ctrl vsc_mode_ctrl_checker vsc_mode_ctrl_checker_inst (.*);

// *** sim/vsc_mode_ctrl_tb.sv ***
// Bench for the mode control register.
// Assumes zero-wait APB and a pulsed update point.
`timescale 1ns/1ps
module vsc_mode_ctrl_tb;
    localparam logic [15:0] ALT [4] = '{16'h2222, 16'h4444, 16'h7776, 16'h4448};
    logic clk_in = 0, srst_in = 1, psel = 0, penable = 0, pwrite = 0, upd = 0;
    logic pready, pslverr, e, cp, pp, sae, gca, bm1, btt;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, q;
    logic [3:0] hold, fre;
    logic [2:0] spi;
    vsc_pkg::vsc_alt_s [3:0] alt;
    int n_mismatch = 0, cmp_count = 0;
    vsc_mode_ctrl vsc_mode_ctrl_inst (.clk_in, .srst_in, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .sequence_change_update_point_in(upd),
        .clamp_start_polarity_out(cp), .preblank_start_polarity_out(pp), .hold_enable_out(hold),
        .special_alternation_enable_out(sae), .special_pattern_insert_enable_out(spi),
        .group_combine_active_out(gca), .group_alternation_out(alt),
        .final_repeat_length_enable_out(fre), .horizontal_blanking_mode1_out(bm1),
        .horizontal_blanking_test_out(btt));
    initial forever #2 clk_in = ~clk_in;
    task automatic give_verdict();
        if (n_mismatch == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s exp %h seen %h", s, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_in) penable <= 1'h1;
        n = 0;
        do begin @(posedge clk_in); n++; end while (pready !== 1'h1 && n < 50);
        q = prdata; e = pslverr;
        psel <= 1'h0; penable <= 1'h0;
        @(posedge clk_in);
        if (pready !== 1'h1) begin n_mismatch++; give_verdict(); end
    endtask
    task automatic pulse();
        upd <= 1'h1;
        @(posedge clk_in) upd <= 1'h0;
        @(posedge clk_in);
    endtask
    task automatic t_fields();
        apb(1'h1, 12'h000, 32'h0019c6e9);
        apb(1'h0, 12'h000, 32'h0);
        chk("pend", 32'(hold), 32'h0);
        chk("rd", q, 32'h0019c6e9);
        apb(1'h0, 12'h004, 32'h0);
        chk("stat", q, 32'h3);
        pulse();
        chk("comb", 32'(gca), 32'h1);
        chk("hb1", 32'(bm1), 32'h1);
        chk("mode", 32'(alt), 32'(ALT[3]));
        chk("hold", 32'(hold), 32'ha);
        chk("salt", 32'(sae), 32'h1);
        chk("ins", 32'(spi), 32'h5);
        chk("fin", 32'(fre), 32'h9);
        chk("pol", 32'({pp, cp}), 32'h1);
        apb(1'h0, 12'h004, 32'h0);
        chk("stat", q, 32'h2);
        chk("err", 32'(e), 32'h0);
    endtask
    task automatic t_modes();
        for (int i = 0; i < 4; i++) begin
            apb(1'h1, 12'h000, 32'(((i & 1) << 20) | (i << 14) | (i << 10)));
            pulse();
            chk("mode", 32'(alt), 32'(ALT[i]));
            chk("comb", 32'(gca), 32'(i == 1));
            chk("hb1", 32'(bm1), 32'((i & 1) == 1));
            chk("hbt", 32'(btt), 32'h0);
        end
    endtask
    task automatic t_err();
        apb(1'h1, 12'h004, 32'h1);
        chk("err", 32'(e), 32'h1);
        apb(1'h0, 12'h008, 32'h0);
        chk("err", 32'(e), 32'h1);
        chk("rd", q, 32'h0);
        apb(1'h0, 12'h000, 32'h0);
        chk("err", 32'(e), 32'h0);
        chk("rd", q, 32'h0010cc00);
    endtask
    task automatic t_rst();
        srst_in <= 1'h1;
        @(posedge clk_in) srst_in <= 1'h0;
        @(posedge clk_in);
        chk("mode", 32'(alt), 32'(ALT[0]));
        apb(1'h0, 12'h000, 32'h0);
        chk("rd", q, 32'h0);
        apb(1'h0, 12'h004, 32'h0);
        chk("stat", q, 32'h0);
    endtask
    initial begin
        repeat (20) @(posedge clk_in);
        srst_in <= 1'h0;
        @(posedge clk_in);
        t_fields();
        t_modes();
        t_err();
        t_rst();
        give_verdict();
    end
endmodule
